// File: inc/diag_flush_pkg.sv
// Shared constants and types for the diagnostic and cache flush command block
package diag_flush_pkg;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [3:0] OFS_COMMAND = 4'h0;
   localparam logic [3:0] OFS_ERROR = 4'h1;
   localparam logic [3:0] OFS_STATE = 4'h2;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
   localparam logic [3:0] OFS_IRQ_ENABLE = 4'h4;
   localparam logic [3:0] OFS_IRQ_CLEAR = 4'h5;

   // Command codes
   localparam logic [7:0] CMD_DIAG = 8'h90;
   localparam logic [7:0] CMD_FLUSH = 8'he7;
   localparam logic [7:0] CMD_FLUSH_EXT = 8'hea;

   // Status flag positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;

   // Error flag positions
   localparam int ER_ABT = 2;

   // Interrupt event positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_W = 2;

   // Reset values
   localparam logic [7:0] STATE_RST = 8'h50;
   localparam logic [7:0] ERROR_RST = 8'h00;
   localparam logic [1:0] IRQ_EN_RST = 2'h0;

   typedef enum logic [1:0] {
      CTL_IDLE = 2'b00,
      CTL_DIAG = 2'b01,
      CTL_FLUSH = 2'b10
   } ctl_state_t;

   // One register access from the host side
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Result from the self test engine
   typedef struct packed {
      logic done;
      logic [7:0] code;
   } diag_rsp_t;

   // Report from the media write-back engine
   typedef struct packed {
      logic done;
      logic fail;
      logic dirty;
   } flush_rsp_t;

endpackage : diag_flush_pkg

// File: hw/diag_flush_ctl.sv
// Command interpreter for self test and write cache flush commands
`timescale 1ns/10ps

// Overview of operation
// - Command 90h starts the internal self test engine.
// - Self test result code is loaded into the error register at completion.
// - After self test the error register is a code, not flag bits.
// - Command E7h writes every dirty cached block to the media.
// - Command EAh performs the same complete write-back as E7h.
// - Flush reports good status only when the cache holds no dirty data.
// - Flush keeps writing back until no cached write data remains or a pass fails, which ends it with abort.
module diag_flush_ctl import diag_flush_pkg::*; (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire reg_req_t host_req,
   output logic [DATA_W-1:0] rdata,
   output logic selftest_start,
   input wire diag_rsp_t selftest_rsp,
   output logic flush_start,
   input wire flush_rsp_t flush_rsp,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Command sequencing

   ctl_state_t state_ff, nxt_state;
   logic [7:0] err_ff, nxt_err;
   logic [7:0] stat_ff, nxt_stat;
   logic diag_go_ff, nxt_diag_go;
   logic flush_go_ff, nxt_flush_go;
   logic ev_done, ev_fail;
   logic cmd_wr;

   assign cmd_wr = host_req.wr && (host_req.addr == OFS_COMMAND);

   always_comb begin
      nxt_state = state_ff;
      nxt_err = err_ff;
      nxt_stat = stat_ff;
      nxt_diag_go = 1'b0;
      nxt_flush_go = 1'b0;
      ev_done = 1'b0;
      ev_fail = 1'b0;
      case (state_ff)
         CTL_IDLE: begin
            // Commands written while busy are dropped; the host must poll busy
            if (cmd_wr) begin
               nxt_err = ERROR_RST;
               nxt_stat[ST_ERR] = 1'b0;
               nxt_stat[ST_DF] = 1'b0;
               nxt_stat[ST_DRQ] = 1'b0;
               case (host_req.wdata)
                  CMD_DIAG: begin
                     nxt_state = CTL_DIAG;
                     nxt_stat[ST_BSY] = 1'b1;
                     nxt_diag_go = 1'b1;
                  end
                  CMD_FLUSH, CMD_FLUSH_EXT: begin
                     // Both opcodes share one write-back path
                     nxt_state = CTL_FLUSH;
                     nxt_stat[ST_BSY] = 1'b1;
                     nxt_flush_go = 1'b1;
                  end
                  default: begin
                     // Opcodes outside this block end at once with abort
                     nxt_err[ER_ABT] = 1'b1;
                     nxt_stat[ST_ERR] = 1'b1;
                     ev_fail = 1'b1;
                  end
               endcase
            end
         end
         CTL_DIAG: begin
            if (selftest_rsp.done) begin
               nxt_state = CTL_IDLE;
               nxt_err = selftest_rsp.code;
               nxt_stat[ST_ERR] = 1'b0;
               nxt_stat[ST_BSY] = 1'b0;
               ev_done = 1'b1;
            end
         end
         CTL_FLUSH: begin
            if (flush_rsp.fail) begin
               nxt_state = CTL_IDLE;
               nxt_err[ER_ABT] = 1'b1;
               nxt_stat[ST_ERR] = 1'b1;
               nxt_stat[ST_BSY] = 1'b0;
               ev_fail = 1'b1;
            end else if (flush_rsp.done && flush_rsp.dirty) begin
               // Data was cached while the pass ran, so start another pass
               nxt_flush_go = 1'b1;
            end else if (flush_rsp.done) begin
               nxt_state = CTL_IDLE;
               nxt_stat[ST_BSY] = 1'b0;
               ev_done = 1'b1;
            end
         end
         default: begin
            nxt_state = CTL_IDLE;
            nxt_stat[ST_BSY] = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= CTL_IDLE;
         err_ff <= ERROR_RST;
         stat_ff <= STATE_RST;
         diag_go_ff <= 1'b0;
         flush_go_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         err_ff <= nxt_err;
         stat_ff <= nxt_stat;
         diag_go_ff <= nxt_diag_go;
         flush_go_ff <= nxt_flush_go;
      end
   end

   assign selftest_start = diag_go_ff;
   assign flush_start = flush_go_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and clear

   logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
   logic [IRQ_W-1:0] irq_en_ff, nxt_irq_en;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_set = '0;
      irq_set[IRQ_DONE] = ev_done;
      irq_set[IRQ_FAIL] = ev_fail;
      irq_clr = '0;
      if (host_req.wr && (host_req.addr == OFS_IRQ_CLEAR)) begin
         irq_clr = host_req.wdata[IRQ_W-1:0];
      end
      // A new event in the clearing cycle is kept
      nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
      nxt_irq_en = irq_en_ff;
      if (host_req.wr && (host_req.addr == OFS_IRQ_ENABLE)) begin
         nxt_irq_en = host_req.wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_ff <= '0;
         irq_en_ff <= IRQ_EN_RST;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_en_ff <= nxt_irq_en;
      end
   end

   assign irq = |(irq_stat_ff & irq_en_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the read strobe

   logic [DATA_W-1:0] rdata_ff, nxt_rdata;

   always_comb begin
      nxt_rdata = '0;
      if (host_req.rd) begin
         case (host_req.addr)
            OFS_ERROR: nxt_rdata = err_ff;
            OFS_STATE: nxt_rdata = stat_ff;
            OFS_IRQ_STATUS: nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_ff};
            OFS_IRQ_ENABLE: nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_en_ff};
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   chk_diag_launch: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (cmd_wr && state_ff == CTL_IDLE && host_req.wdata == CMD_DIAG)
      |=> (selftest_start && stat_ff[ST_BSY] && state_ff == CTL_DIAG)
   ) else $error("self test not launched after its command");

   chk_diag_code: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == CTL_DIAG && selftest_rsp.done)
      |=> (err_ff == $past(selftest_rsp.code)) ##1 (rdata == $past(err_ff)
         || !$past(host_req.rd) || $past(host_req.addr) != OFS_ERROR)
   ) else $error("diagnostic code not held in error register");

   chk_diag_no_flag: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == CTL_DIAG && selftest_rsp.done)
      |=> (!stat_ff[ST_ERR] && !stat_ff[ST_BSY] && irq_stat_ff[IRQ_DONE])
   ) else $error("self test completion status wrong");

   chk_flush_launch: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (cmd_wr && state_ff == CTL_IDLE && host_req.wdata == CMD_FLUSH)
      |=> (flush_start && state_ff == CTL_FLUSH) ##1 !flush_start
   ) else $error("flush not launched after its command");

   chk_flush_ext: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (cmd_wr && state_ff == CTL_IDLE && host_req.wdata == CMD_FLUSH_EXT)
      |=> (flush_start && stat_ff[ST_BSY] && state_ff == CTL_FLUSH)
   ) else $error("extended flush not launched after its command");

   chk_good_clean: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      ($past(state_ff) == CTL_FLUSH && $fell(stat_ff[ST_BSY]) && !stat_ff[ST_ERR])
      |-> ($past(flush_rsp.done) && !$past(flush_rsp.dirty))
   ) else $error("good flush status with dirty cache");

   chk_flush_retry: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == CTL_FLUSH && flush_rsp.done && flush_rsp.dirty && !flush_rsp.fail)
      |=> (flush_start && stat_ff[ST_BSY] && state_ff == CTL_FLUSH)
   ) else $error("flush ended with write data left in cache");

   chk_flush_abort: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == CTL_FLUSH && flush_rsp.fail)
      |=> (err_ff[ER_ABT] && stat_ff[ST_ERR] && !stat_ff[ST_BSY]
         && state_ff == CTL_IDLE)
   ) else $error("failed flush not reported as abort");

   chk_irq_sticky: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (ev_done && host_req.wr && host_req.addr == OFS_IRQ_CLEAR)
      |=> irq_stat_ff[IRQ_DONE]
   ) else $error("completion event lost against clear");

endmodule : diag_flush_ctl

// File: dv/engine_model.sv
// Behavioural self test and write-back engines on the far side of the block
`timescale 1ns/10ps
module engine_model import diag_flush_pkg::*; (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic selftest_start,
   input wire logic flush_start,
   input wire logic [7:0] code,
   input wire logic [3:0] passes,
   input wire logic fail_mode,
   output diag_rsp_t selftest_rsp,
   output flush_rsp_t flush_rsp
);
   int d_cnt, f_cnt, n_done;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         d_cnt = 0;
         f_cnt = 0;
         n_done = 0;
         selftest_rsp <= '0;
         flush_rsp <= '0;
      end else begin
         // Code shown inverted away from done so a stale value never looks right
         selftest_rsp <= '{d_cnt == 1, (d_cnt == 1) ? code : ~code};
         flush_rsp.done <= (f_cnt == 1) && !fail_mode;
         flush_rsp.fail <= (f_cnt == 1) && fail_mode;
         // Cache stays dirty until the last needed pass lands
         flush_rsp.dirty <= (n_done + 1 < int'(passes)) && !fail_mode;
         if (f_cnt == 1) n_done = (fail_mode || n_done + 1 >= int'(passes)) ? 0 : n_done + 1;
         d_cnt = selftest_start ? 6 : (d_cnt > 0 ? d_cnt - 1 : 0);
         f_cnt = flush_start ? 6 : (f_cnt > 0 ? f_cnt - 1 : 0);
      end
   end
endmodule : engine_model

// File: dv/diag_flush_ctl_tb_top.sv
// Self-checking bench for the diagnostic and cache flush command block
`timescale 1ns/10ps
module diag_flush_ctl_tb_top;
   import diag_flush_pkg::*;
   typedef struct {logic [7:0] cmd, code; logic [3:0] np; logic fl; logic [7:0] er, st, ev;
      int nd, nf;} row_t;
   logic sys_clk, arst_n, selftest_start, flush_start, irq, fail_mode, b;
   logic [7:0] rdata, code, d;
   logic [3:0] passes;
   reg_req_t host_req;
   diag_rsp_t selftest_rsp;
   flush_rsp_t flush_rsp;
   int fail_count, n_checks, n_diag, n_flush;
   row_t rows[7];
   logic [3:0] ra[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
   logic [7:0] re[5] = '{8'h00, 8'h50, 8'h00, 8'h00, 8'h00};

   diag_flush_ctl dut (.sys_clk(sys_clk), .arst_n(arst_n), .host_req(host_req), .rdata(rdata),
      .selftest_start(selftest_start), .selftest_rsp(selftest_rsp),
      .flush_start(flush_start), .flush_rsp(flush_rsp), .irq(irq));
   engine_model eng (.sys_clk(sys_clk), .arst_n(arst_n), .selftest_start(selftest_start),
      .flush_start(flush_start), .code(code), .passes(passes), .fail_mode(fail_mode),
      .selftest_rsp(selftest_rsp), .flush_rsp(flush_rsp));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (selftest_start === 1'b1) n_diag++;
      if (flush_start === 1'b1) n_flush++;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      host_req <= '{a, v, 1'b1, 1'b0};
      @(posedge sys_clk);
      host_req.wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      host_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      host_req.rd <= 1'b0;
      @(posedge sys_clk);
      v = rdata;
   endtask : rd_reg

   // First poll also reports whether busy was raised at all
   task automatic wait_idle(output logic first_bsy);
      for (int k = 0; k < 100; k++) begin
         rd_reg(OFS_STATE, d);
         if (k == 0) first_bsy = d[ST_BSY];
         if (d[ST_BSY] === 1'b0) return;
      end
      fail_count++;
      end_of_test();
   endtask : wait_idle

   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
   endtask : do_reset

   initial begin
      host_req = '0;
      code = 8'h00;
      passes = 4'h1;
      fail_mode = 1'b0;
      arst_n = 1'b0;
      rows = '{'{CMD_DIAG, 8'h01, 4'h1, 1'b0, 8'h01, 8'h50, 8'h01, 1, 0},
         '{CMD_DIAG, 8'h84, 4'h1, 1'b0, 8'h84, 8'h50, 8'h01, 1, 0},
         '{CMD_FLUSH, 8'h00, 4'h1, 1'b0, 8'h00, 8'h50, 8'h01, 0, 1},
         '{CMD_FLUSH_EXT, 8'h00, 4'h3, 1'b0, 8'h00, 8'h50, 8'h01, 0, 3},
         '{CMD_FLUSH, 8'h00, 4'h2, 1'b1, 8'h04, 8'h51, 8'h02, 0, 1},
         '{CMD_FLUSH_EXT, 8'h00, 4'h1, 1'b1, 8'h04, 8'h51, 8'h02, 0, 1},
         '{8'h50, 8'h00, 4'h1, 1'b0, 8'h04, 8'h51, 8'h02, 0, 0}};
      do_reset();
      wr_reg(OFS_IRQ_ENABLE, 8'h03);
      foreach (rows[i]) begin
         code <= rows[i].code;
         passes <= rows[i].np;
         fail_mode <= rows[i].fl;
         n_diag = 0;
         n_flush = 0;
         wr_reg(OFS_IRQ_CLEAR, 8'h03);
         wr_reg(OFS_COMMAND, rows[i].cmd);
         wait_idle(b);
         chk({7'h0, b}, 8'(rows[i].nd + rows[i].nf > 0));
         rd_reg(OFS_ERROR, d);
         chk(d, rows[i].er);
         rd_reg(OFS_STATE, d);
         chk(d, rows[i].st);
         rd_reg(OFS_IRQ_STATUS, d);
         chk(d, rows[i].ev);
         chk({7'h0, irq}, 8'h01);
         chk(8'(n_diag), 8'(rows[i].nd));
         chk(8'(n_flush), 8'(rows[i].nf));
         $display("row %0d end", i);
      end
      // A command arriving while busy is dropped
      passes <= 4'h2;
      fail_mode <= 1'b0;
      n_diag = 0;
      n_flush = 0;
      wr_reg(OFS_COMMAND, CMD_FLUSH);
      wr_reg(OFS_COMMAND, CMD_DIAG);
      wait_idle(b);
      chk(8'(n_diag), 8'h00);
      chk(8'(n_flush), 8'h02);
      $display("busy drop end");
      wr_reg(OFS_IRQ_CLEAR, 8'h03);
      wr_reg(OFS_IRQ_ENABLE, 8'h02);
      wr_reg(OFS_COMMAND, CMD_DIAG);
      wait_idle(b);
      rd_reg(OFS_IRQ_ENABLE, d);
      chk(d, 8'h02);
      rd_reg(OFS_IRQ_STATUS, d);
      chk(d, 8'h01);
      chk({7'h0, irq}, 8'h00);
      wr_reg(OFS_IRQ_ENABLE, 8'h01);
      @(posedge sys_clk);
      chk({7'h0, irq}, 8'h01);
      wr_reg(OFS_IRQ_CLEAR, 8'h01);
      @(posedge sys_clk);
      chk({7'h0, irq}, 8'h00);
      $display("irq mask end");
      // Clear lands in the very cycle the self test reports done
      wr_reg(OFS_COMMAND, CMD_DIAG);
      repeat (6) @(posedge sys_clk);
      wr_reg(OFS_IRQ_CLEAR, 8'h01);
      wait_idle(b);
      rd_reg(OFS_IRQ_STATUS, d);
      chk(d, 8'h01);
      $display("set beats clear end");
      do_reset();
      wr_reg(4'hf, 8'hff);
      foreach (ra[j]) begin
         rd_reg(ra[j], d);
         chk(d, re[j]);
      end
      chk({7'h0, irq}, 8'h00);
      $display("reset end");
      end_of_test();
   end
endmodule : diag_flush_ctl_tb_top
